/* pot_pkg.sv */
// constants shared by both ends of the serial link to the digital potentiometer.
// assumes a single 25 MHz system clock on both sides and synchronous pin sampling.
package pot_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and nonvolatile write timing
  localparam int CLK_KHZ = 25000;
  localparam int NV_WRITE_TIME_MS = 10;
  // longest write time in whole system clock cycles, exactly milliseconds times kilohertz
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * CLK_KHZ;
  localparam int NV_CNT_W = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // wiper and register sizes
  localparam int WIPER_W = 10;
  localparam int TAPS = 1024;
  localparam int NUM_DATA_REGS = 4;
  localparam int PTR_W = 2;
  localparam logic [WIPER_W-1:0] DR_FACTORY = 10'h200;

  ////////////////////////////////////////////////////////////////////////////////
  // frame layout: id byte, instruction byte, then two data bytes
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int FRAME_BITS = 32;
  localparam int SHORT_FRAME_BITS = 16;
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] LAST_FRAME_BIT = 6'h1f;
  localparam logic [2:0] LAST_BYTE_BIT = 3'h7;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  // id byte: type in [7:4], [3:2] zero, device address bit [1], read flag [0]
  localparam int ID_TYPE_LSB = 4;
  localparam int ID_ADDR_BIT = 1;
  localparam int ID_RW_BIT = 0;
  // value is arbitrary
  localparam logic [3:0] DEVICE_TYPE = 4'ha;

  // instruction byte: opcode in [7:5], register pointer in [1:0]
  localparam int OP_LSB = 5;
  localparam logic [2:0] OP_XFR_DR_TO_WIPER = 3'h1;
  localparam logic [2:0] OP_RD_STATUS = 3'h2;
  localparam logic [2:0] OP_XFR_WIPER_TO_DR = 3'h3;
  localparam logic [2:0] OP_RD_WIPER = 3'h4;
  localparam logic [2:0] OP_WR_WIPER = 3'h5;
  localparam logic [2:0] OP_RD_DATA = 3'h6;
  localparam logic [2:0] OP_WR_DATA = 3'h7;

  // host serial clock: half period in system clocks
  localparam int SCK_HALF_CYCLES = 2;

endpackage

/* pot_spi_if.sv */
// serial pins between the potentiometer and its host controller.
// the serial output is tri-state; an idle line reads high as if pulled up.
`timescale 1ns/10ps
interface pot_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so;
  logic so_oe;
  logic so_line;

  assign so_line = so_oe ? so : 1'b1;

  modport dev (
    input cs_n,
    input sck,
    input si,
    input hold_n,
    input wp_n,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    output hold_n,
    output wp_n,
    input so_line
  );
endinterface

/* pot_device.sv */
// serial slave and wiper control of one digital potentiometer with four data registers.
// assumes pin inputs already synchronous to clk; rst acts as the power-up event.
`timescale 1ns/10ps

// Function
// - power-up recalls data register zero into wiper
// - 10-bit wiper decoded to one of 1024 taps
// - four data registers, written and read serially
// - read data shifts out on falling clock
// - serial input sampled on rising clock
// - host sends opcodes and data on input
// - host pulls pause low only with clock low
// - pause keeps bit position and instruction state
// - host releases pause only with clock low
// - host not pausing keeps pause high
// - command continues only on address bit match
// - select high: deselected, output high impedance
// - deselected enters standby after any write
// - select low enables device for sequence
// - ignore activity until first select falling edge
// - write-protect low blocks data register writes
// - first byte: type, address bit, direction
// - second byte: opcode and register pointer
// - data register write busy up to 10ms
module pot_device #(
  parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  pot_spi_if.dev spi,
  input wire logic dev_addr_pin,
  output logic [pot_pkg::WIPER_W-1:0] wiper_position_reg,
  output logic [pot_pkg::TAPS-1:0] tap_enable,
  output logic write_busy_flag,
  output logic standby
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [2:0] {
    ST_UNARMED,
    ST_IDLE,
    ST_ID,
    ST_INSTR,
    ST_DATA,
    ST_SKIP
  } dev_state_e;

  typedef struct packed {
    dev_state_e st;
    logic sck_q;
    logic [pot_pkg::WORD_W-1:0] sh;
    logic [pot_pkg::BIT_CNT_W-1:0] bcnt;
    logic rw;
    logic [2:0] op;
    logic [pot_pkg::PTR_W-1:0] ptr;
    logic [pot_pkg::WORD_W-1:0] out_sh;
    logic so;
    logic so_oe;
    logic [pot_pkg::WIPER_W-1:0] wiper;
    logic [pot_pkg::TAPS-1:0] taps;
    logic [pot_pkg::NUM_DATA_REGS-1:0][pot_pkg::WIPER_W-1:0] dr;
    logic recall;
    logic busy;
    logic [pot_pkg::NV_CNT_W-1:0] nv_cnt;
    logic [pot_pkg::PTR_W-1:0] nv_ptr;
    logic [pot_pkg::WIPER_W-1:0] nv_data;
    logic standby;
  } dev_s;

  localparam dev_s RESET_VAL = '{
    st: ST_UNARMED,
    sck_q: 1'b0,
    sh: pot_pkg::WORD_ZERO,
    bcnt: '0,
    rw: 1'b0,
    op: '0,
    ptr: '0,
    out_sh: pot_pkg::WORD_ZERO,
    so: 1'b0,
    so_oe: 1'b0,
    wiper: '0,
    taps: pot_pkg::TAPS'(1),
    dr: {pot_pkg::NUM_DATA_REGS{pot_pkg::DR_FACTORY}},
    recall: 1'b1,
    busy: 1'b0,
    nv_cnt: '0,
    nv_ptr: '0,
    nv_data: '0,
    standby: 1'b1
  };

  localparam logic [pot_pkg::NV_CNT_W-1:0] NV_LAST = pot_pkg::NV_CNT_W'(NV_WRITE_CYCLES - 1);

  dev_s r;
  dev_s next_r;

  logic active;
  logic rise_en;
  logic fall_en;
  logic byte_end;
  logic [pot_pkg::BYTE_W-1:0] byte_v;
  logic [pot_pkg::WORD_W-1:0] word_v;
  logic [2:0] op_v;
  logic op_is_read;
  logic cur_is_read;
  logic nv_allowed;
  logic [pot_pkg::TAPS-1:0] tap_dec;

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection and byte assembly

  // pause freezes edge detection, so counters and opcode simply wait
  assign active = ~spi.cs_n & spi.hold_n;
  assign rise_en = active & spi.sck & ~r.sck_q;
  assign fall_en = active & ~spi.sck & r.sck_q;
  assign byte_v = {r.sh[pot_pkg::BYTE_W-2:0], spi.si};
  assign word_v = {r.sh[pot_pkg::WORD_W-2:0], spi.si};
  assign byte_end = rise_en & (r.bcnt[2:0] == pot_pkg::LAST_BYTE_BIT);
  assign op_v = byte_v[pot_pkg::BYTE_W-1:pot_pkg::OP_LSB];
  assign op_is_read = (op_v == pot_pkg::OP_RD_WIPER) || (op_v == pot_pkg::OP_RD_DATA) ||
                      (op_v == pot_pkg::OP_RD_STATUS);
  assign cur_is_read = (r.op == pot_pkg::OP_RD_WIPER) || (r.op == pot_pkg::OP_RD_DATA) ||
                       (r.op == pot_pkg::OP_RD_STATUS);
  // a second write while one is running is dropped rather than queued
  assign nv_allowed = spi.wp_n & ~r.busy;

  // one comparator per tap; only one can match
  for (genvar i = 0; i < pot_pkg::TAPS; i++) begin : g_tap
    assign tap_dec[i] = (r.wiper == pot_pkg::WIPER_W'(i));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.sck_q = spi.sck;
    next_r.taps = tap_dec;

    // nonvolatile write timer; the array updates only when the cycle ends
    if (r.busy) begin
      if (r.nv_cnt == NV_LAST) begin
        next_r.busy = 1'b0;
        next_r.nv_cnt = '0;
        next_r.dr[r.nv_ptr] = r.nv_data;
      end else begin
        next_r.nv_cnt = r.nv_cnt + 1'b1;
      end
    end

    if (r.recall) begin
      next_r.wiper = r.dr[0];
      next_r.recall = 1'b0;
    end

    if (rise_en) begin
      next_r.sh = word_v;
      next_r.bcnt = r.bcnt + 1'b1;
    end

    if (r.st != ST_UNARMED && spi.cs_n) begin
      next_r.st = ST_IDLE;
      next_r.so_oe = 1'b0;
    end else begin
      case (r.st)
        ST_UNARMED: begin
          // a frame already running at power-up is ignored
          if (spi.cs_n) begin
            next_r.st = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!spi.cs_n) begin
            next_r.st = ST_ID;
            next_r.bcnt = '0;
          end
        end
        ST_ID: begin
          if (byte_end) begin
            if (byte_v[pot_pkg::BYTE_W-1:pot_pkg::ID_TYPE_LSB] == pot_pkg::DEVICE_TYPE &&
                byte_v[pot_pkg::ID_ADDR_BIT] == dev_addr_pin) begin
              next_r.rw = byte_v[pot_pkg::ID_RW_BIT];
              next_r.st = ST_INSTR;
            end else begin
              next_r.st = ST_SKIP;
            end
          end
        end
        ST_INSTR: begin
          if (byte_end) begin
            next_r.op = op_v;
            next_r.ptr = byte_v[pot_pkg::PTR_W-1:0];
            next_r.st = ST_SKIP;
            case (op_v)
              pot_pkg::OP_XFR_DR_TO_WIPER: begin
                next_r.wiper = r.dr[byte_v[pot_pkg::PTR_W-1:0]];
              end
              pot_pkg::OP_XFR_WIPER_TO_DR: begin
                if (nv_allowed) begin
                  next_r.busy = 1'b1;
                  next_r.nv_ptr = byte_v[pot_pkg::PTR_W-1:0];
                  next_r.nv_data = r.wiper;
                end
              end
              default: begin
                if (op_is_read == r.rw) begin
                  next_r.st = ST_DATA;
                end
              end
            endcase
            case (op_v)
              pot_pkg::OP_RD_WIPER: next_r.out_sh = pot_pkg::WORD_W'(r.wiper);
              pot_pkg::OP_RD_DATA: begin
                next_r.out_sh = pot_pkg::WORD_W'(r.dr[byte_v[pot_pkg::PTR_W-1:0]]);
              end
              pot_pkg::OP_RD_STATUS: next_r.out_sh = pot_pkg::WORD_W'(r.busy);
              default: next_r.out_sh = pot_pkg::WORD_ZERO;
            endcase
          end
        end
        ST_DATA: begin
          if (fall_en && cur_is_read) begin
            next_r.so = r.out_sh[pot_pkg::WORD_W-1];
            next_r.out_sh = {r.out_sh[pot_pkg::WORD_W-2:0], 1'b0};
            next_r.so_oe = 1'b1;
          end
          if (rise_en && r.bcnt == pot_pkg::LAST_FRAME_BIT) begin
            next_r.st = ST_SKIP;
            next_r.so_oe = 1'b0;
            if (r.op == pot_pkg::OP_WR_WIPER) begin
              next_r.wiper = word_v[pot_pkg::WIPER_W-1:0];
            end else if (r.op == pot_pkg::OP_WR_DATA && nv_allowed) begin
              next_r.busy = 1'b1;
              next_r.nv_ptr = r.ptr;
              next_r.nv_data = word_v[pot_pkg::WIPER_W-1:0];
            end
          end
        end
        ST_SKIP: begin
          next_r.so_oe = 1'b0;
        end
        default: begin
          next_r.st = ST_IDLE;
        end
      endcase
    end

    next_r.standby = spi.cs_n & ~next_r.busy;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and outputs

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign spi.so = r.so;
  assign spi.so_oe = r.so_oe;
  assign wiper_position_reg = r.wiper;
  assign tap_enable = r.taps;
  assign write_busy_flag = r.busy;
  assign standby = r.standby;

endmodule

/* pot_host.sv */
// host controller that frames commands to the potentiometer over the serial pins.
// assumes the user side holds command fields stable while start is presented.
`timescale 1ns/10ps
module pot_host #(
  parameter int SCK_HALF_CYCLES = pot_pkg::SCK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  pot_spi_if.host spi,
  input wire logic start,
  input wire logic [2:0] opcode,
  input wire logic [pot_pkg::PTR_W-1:0] reg_ptr,
  input wire logic addr_bit,
  input wire logic [pot_pkg::WIPER_W-1:0] wdata,
  input wire logic pause,
  input wire logic write_protect_n,
  output logic busy,
  output logic done,
  output logic [pot_pkg::WORD_W-1:0] rdata
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_LOW,
    H_HIGH,
    H_TAIL
  } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [7:0] div;
    logic [pot_pkg::FRAME_BITS-1:0] frame;
    logic [pot_pkg::BIT_CNT_W-1:0] bcnt;
    logic [pot_pkg::BIT_CNT_W-1:0] nbits;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic busy;
    logic done;
    logic [pot_pkg::WORD_W-1:0] rdata;
  } host_s;

  localparam host_s RESET_VAL = '{
    st: H_IDLE, div: '0, frame: '0, bcnt: '0, nbits: '0, cs_n: 1'b1, sck: 1'b0,
    si: 1'b0, hold_n: 1'b1, wp_n: 1'b1, busy: 1'b0, done: 1'b0,
    rdata: pot_pkg::WORD_ZERO
  };
  localparam logic [7:0] DIV_LAST = 8'(SCK_HALF_CYCLES - 1);

  host_s r;
  host_s next_r;
  logic tick;
  logic is_read;
  logic is_xfr;
  logic [pot_pkg::FRAME_BITS-1:0] new_frame;

  ////////////////////////////////////////////////////////////////////////////////
  // frame building

  assign tick = (r.div == DIV_LAST);
  assign is_read = (opcode == pot_pkg::OP_RD_WIPER) || (opcode == pot_pkg::OP_RD_DATA) ||
                   (opcode == pot_pkg::OP_RD_STATUS);
  assign is_xfr = (opcode == pot_pkg::OP_XFR_DR_TO_WIPER) ||
                  (opcode == pot_pkg::OP_XFR_WIPER_TO_DR);
  // everything goes out on the data input line
  assign new_frame = {pot_pkg::DEVICE_TYPE, 2'b00, addr_bit, is_read,
                      opcode, 3'b000, reg_ptr, pot_pkg::WORD_W'(wdata)};

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.wp_n = write_protect_n;
    next_r.div = tick ? 8'h00 : r.div + 8'h01;
    if (tick) begin
      case (r.st)
        H_IDLE: begin
          // select idles high, so every frame begins with a falling edge
          if (start) begin
            next_r.st = H_LOW;
            next_r.cs_n = 1'b0;
            next_r.busy = 1'b1;
            next_r.frame = new_frame;
            next_r.si = new_frame[pot_pkg::FRAME_BITS-1];
            next_r.bcnt = '0;
            next_r.nbits = is_xfr ? pot_pkg::BIT_CNT_W'(pot_pkg::SHORT_FRAME_BITS) :
                                    pot_pkg::BIT_CNT_W'(pot_pkg::FRAME_BITS);
          end
        end
        H_LOW: begin
          // pause changes only while the clock is low
          if (pause) begin
            next_r.hold_n = 1'b0;
          end else if (!r.hold_n) begin
            next_r.hold_n = 1'b1;
          end else begin
            next_r.sck = 1'b1;
            next_r.rdata = {r.rdata[pot_pkg::WORD_W-2:0], spi.so_line};
            next_r.bcnt = r.bcnt + 1'b1;
            next_r.st = H_HIGH;
          end
        end
        H_HIGH: begin
          next_r.sck = 1'b0;
          if (r.bcnt == r.nbits) begin
            next_r.st = H_TAIL;
          end else begin
            next_r.frame = {r.frame[pot_pkg::FRAME_BITS-2:0], 1'b0};
            next_r.si = r.frame[pot_pkg::FRAME_BITS-2];
            next_r.st = H_LOW;
          end
        end
        H_TAIL: begin
          next_r.cs_n = 1'b1;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st = H_IDLE;
        end
        default: next_r.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign spi.cs_n = r.cs_n;
  assign spi.sck = r.sck;
  assign spi.si = r.si;
  assign spi.hold_n = r.hold_n;
  assign spi.wp_n = r.wp_n;
  assign busy = r.busy;
  assign done = r.done;
  assign rdata = r.rdata;

endmodule

/* pot_link_sva.sv */
// checker for the serial pins between the potentiometer and its host controller.
// assumes one system clock, synchronous active-high rst, pins sampled on the rising clock.
`timescale 1ns/10ps
module pot_link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  typedef struct packed {
    logic sck_q;
    logic cs_q;
    logic armed;
    logic [5:0] edges;
  } mon_s;
  mon_s cur;
  mon_s next_cur;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // rising serial clock edges of the current frame, counted on the same clock as the device
  always_comb begin
    next_cur = cur;
    next_cur.sck_q = sck;
    next_cur.cs_q = cs_n;
    if (cur.cs_q && !cs_n) begin
      next_cur.armed = 1'b1;
    end
    if (cs_n) begin
      next_cur.edges = 6'h00;
    end else if (hold_n && sck && !cur.sck_q) begin
      next_cur.edges = cur.edges + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_off_deselected;
    cs_n && $past(cs_n) |-> !so_oe;
  endproperty
  a_off_deselected: assert property (p_off_deselected)
    else $error("serial output driven while deselected");

  // a new bit appears exactly one clock after the serial clock fell
  property p_so_on_fall;
    so_oe && $past(so_oe) && $changed(so) |-> !sck && !$past(sck) && $past(sck, 2);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall)
    else $error("serial output changed off the falling clock");

  property p_hold_freeze;
    !hold_n && !$past(hold_n) && !$past(hold_n, 2) |-> $stable(so) && $stable(so_oe);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("serial output moved during pause");

  property p_hold_low_clock;
    $changed(hold_n) |-> !sck;
  endproperty
  a_hold_low_clock: assert property (p_hold_low_clock)
    else $error("pause changed while serial clock high");

  property p_oe_at_16;
    $rose(so_oe) |-> cur.edges == 6'h10;
  endproperty
  a_oe_at_16: assert property (p_oe_at_16)
    else $error("output enabled outside the read data phase");

  property p_oe_drop_32;
    cur.edges == 6'h20 |-> ##[1:3] !so_oe;
  endproperty
  a_oe_drop_32: assert property (p_oe_drop_32)
    else $error("output still enabled after the last bit");

  property p_armed;
    $rose(so_oe) |-> cur.armed;
  endproperty
  a_armed: assert property (p_armed)
    else $error("device answered before a select falling edge");

  property p_id_first;
    $fell(cs_n) |-> si == pot_pkg::DEVICE_TYPE[3] && !sck;
  endproperty
  a_id_first: assert property (p_id_first)
    else $error("frame does not open with the type field");

  c_frame: cover property ($fell(cs_n));
  c_read: cover property ($rose(so_oe));
  c_pause: cover property ($fell(hold_n));
endmodule

/* spi_digital_pot_interface_tb_top.sv */
// testbench joining the potentiometer and its host controller through the serial pins.
// assumes a 25 MHz clock and a shortened nonvolatile write time.
`timescale 1ns/10ps
`define check_eq(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module spi_digital_pot_interface_tb_top;
  // long enough that a status read fits inside one write
  localparam int NV_CYC = 400;
  localparam int LIMIT = 30000;
  localparam logic [pot_pkg::TAPS-1:0] ONE = 1;
  typedef struct packed {
    logic [2:0] op;
    logic [1:0] ptr;
    logic addr;
    logic [9:0] wd;
    logic [9:0] ew;
    logic chk;
    logic [15:0] er;
  } row_s;
  logic clk, rst, start, addr_bit, pause, write_protect_n, dev_addr_pin;
  logic [2:0] opcode;
  logic [1:0] reg_ptr;
  logic [9:0] wdata, wiper_position_reg;
  logic [pot_pkg::TAPS-1:0] tap_enable;
  logic write_busy_flag, standby, busy, done;
  // restarts the device alone, so the host can keep a frame running across it
  logic dev_rst;
  logic [15:0] rdata;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  row_s rows [13] = '{
    '{pot_pkg::OP_RD_WIPER, 2'h0, 1'b1, 10'h000, 10'h200, 1'b1, 16'h0200},
    '{pot_pkg::OP_WR_WIPER, 2'h0, 1'b1, 10'h3ff, 10'h3ff, 1'b0, 16'h0000},
    '{pot_pkg::OP_RD_WIPER, 2'h0, 1'b1, 10'h000, 10'h3ff, 1'b1, 16'h03ff},
    '{pot_pkg::OP_WR_DATA, 2'h2, 1'b1, 10'h155, 10'h3ff, 1'b0, 16'h0000},
    '{pot_pkg::OP_RD_DATA, 2'h2, 1'b1, 10'h000, 10'h3ff, 1'b1, 16'h0155},
    '{pot_pkg::OP_RD_DATA, 2'h1, 1'b1, 10'h000, 10'h3ff, 1'b1, 16'h0200},
    '{pot_pkg::OP_XFR_DR_TO_WIPER, 2'h2, 1'b1, 10'h000, 10'h155, 1'b0, 16'h0000},
    '{pot_pkg::OP_XFR_WIPER_TO_DR, 2'h3, 1'b1, 10'h000, 10'h155, 1'b0, 16'h0000},
    '{pot_pkg::OP_RD_DATA, 2'h3, 1'b1, 10'h000, 10'h155, 1'b1, 16'h0155},
    '{pot_pkg::OP_WR_WIPER, 2'h0, 1'b0, 10'h001, 10'h155, 1'b0, 16'h0000},
    '{pot_pkg::OP_RD_WIPER, 2'h0, 1'b0, 10'h000, 10'h155, 1'b1, 16'hffff},
    '{pot_pkg::OP_RD_STATUS, 2'h0, 1'b1, 10'h000, 10'h155, 1'b1, 16'h0000},
    '{pot_pkg::OP_WR_WIPER, 2'h0, 1'b1, 10'h000, 10'h000, 1'b0, 16'h0000}
  };

  pot_spi_if pot_spi_if_inst();
  pot_device #(.NV_WRITE_CYCLES(NV_CYC)) pot_device_inst (.clk(clk), .rst(rst | dev_rst),
    .spi(pot_spi_if_inst), .dev_addr_pin(dev_addr_pin),
    .wiper_position_reg(wiper_position_reg), .tap_enable(tap_enable),
    .write_busy_flag(write_busy_flag), .standby(standby));
  pot_host pot_host_inst (.clk(clk), .rst(rst), .spi(pot_spi_if_inst), .start(start),
    .opcode(opcode), .reg_ptr(reg_ptr), .addr_bit(addr_bit), .wdata(wdata), .pause(pause),
    .write_protect_n(write_protect_n), .busy(busy), .done(done), .rdata(rdata));
  pot_link_sva pot_link_sva_inst (.clk(clk), .rst(rst), .cs_n(pot_spi_if_inst.cs_n),
    .sck(pot_spi_if_inst.sck), .si(pot_spi_if_inst.si), .hold_n(pot_spi_if_inst.hold_n),
    .so(pot_spi_if_inst.so), .so_oe(pot_spi_if_inst.so_oe));

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic run(input logic [2:0] op, input logic [1:0] ptr, input logic a,
                     input logic [9:0] wd);
    int n;
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    reg_ptr <= ptr;
    addr_bit <= a;
    wdata <= wd;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) fails++;
  endtask

  // bounded wait for the nonvolatile write to finish
  task automatic wait_nv();
    int n;
    n = 0;
    while (write_busy_flag !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) fails++;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      fails++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    rst = 1;
    start = 0;
    opcode = 0;
    reg_ptr = 0;
    addr_bit = 0;
    wdata = 0;
    pause = 0;
    write_protect_n = 1;
    dev_addr_pin = 1;
    dev_rst = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      run(rows[i].op, rows[i].ptr, rows[i].addr, rows[i].wd);
      `check_eq("wiper", rows[i].ew, wiper_position_reg)
      `check_eq("tap", ONE << rows[i].ew, tap_enable)
      if (rows[i].chk) `check_eq("rdata", rows[i].er, rdata)
      wait_nv();
    end
    $display("test table finished");
    write_protect_n <= 1'b0;
    run(pot_pkg::OP_WR_DATA, 2'h1, 1'b1, 10'h0aa);
    `check_eq("busy_wp", 1'b0, write_busy_flag)
    run(pot_pkg::OP_XFR_WIPER_TO_DR, 2'h1, 1'b1, 10'h000);
    `check_eq("xfr_wp", 1'b0, write_busy_flag)
    run(pot_pkg::OP_RD_DATA, 2'h1, 1'b1, 10'h000);
    `check_eq("rd_wp", 16'h0200, rdata)
    write_protect_n <= 1'b1;
    $display("test protect finished");
    run(pot_pkg::OP_WR_DATA, 2'h0, 1'b1, 10'h123);
    `check_eq("standby_busy", 1'b0, standby)
    run(pot_pkg::OP_RD_STATUS, 2'h0, 1'b1, 10'h000);
    `check_eq("status", 16'h0001, rdata)
    `check_eq("busy_flag", 1'b1, write_busy_flag)
    wait_nv();
    repeat (2) @(posedge clk);
    `check_eq("standby_idle", 1'b1, standby)
    run(pot_pkg::OP_RD_DATA, 2'h0, 1'b1, 10'h000);
    `check_eq("rd_new", 16'h0123, rdata)
    $display("test write time finished");
    // with its pin low the device answers to address zero only
    dev_addr_pin <= 1'b0;
    run(pot_pkg::OP_WR_WIPER, 2'h0, 1'b0, 10'h0f0);
    `check_eq("wiper_addr0", 10'h0f0, wiper_position_reg)
    dev_addr_pin <= 1'b1;
    $display("test address pin finished");
    fork
      run(pot_pkg::OP_WR_WIPER, 2'h0, 1'b1, 10'h2aa);
      begin
        repeat (40) @(posedge clk);
        pause <= 1'b1;
        repeat (30) @(posedge clk);
        `check_eq("busy_pause", 1'b1, busy)
        `check_eq("standby_act", 1'b0, standby)
        pause <= 1'b0;
      end
    join
    `check_eq("wiper_pause", 10'h2aa, wiper_position_reg)
    $display("test pause finished");
    // power-up again in mid-frame
    @(posedge clk);
    start <= 1'b1;
    opcode <= pot_pkg::OP_RD_WIPER;
    addr_bit <= 1'b1;
    repeat (30) @(posedge clk);
    start <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `check_eq("wiper_rst", pot_pkg::DR_FACTORY, wiper_position_reg)
    `check_eq("tap_rst", ONE << pot_pkg::DR_FACTORY, tap_enable)
    `check_eq("oe_rst", 1'b0, pot_spi_if_inst.so_oe)
    `check_eq("standby_rst", 1'b1, standby)
    run(pot_pkg::OP_RD_DATA, 2'h2, 1'b1, 10'h000);
    `check_eq("rd_after_rst", 16'h0200, rdata)
    $display("test reset finished");
    // device restarts while select stays low: the rest of that frame must be ignored
    fork
      run(pot_pkg::OP_RD_WIPER, 2'h0, 1'b1, 10'h000);
      begin
        repeat (20) @(posedge clk);
        dev_rst <= 1'b1;
        repeat (2) @(posedge clk);
        dev_rst <= 1'b0;
      end
    join
    `check_eq("rd_unarmed", 16'hffff, rdata)
    run(pot_pkg::OP_RD_WIPER, 2'h0, 1'b1, 10'h000);
    `check_eq("rd_rearmed", 16'h0200, rdata)
    $display("test unarmed finished");
    wrap_up();
  end
endmodule
